// ===== hw/pfta_pkg.sv
// Package: constants and types for the program flash table-access block
package pfta_pkg;
  localparam int PFTA_ADDR_W     = 24;
  localparam int PFTA_EA_W       = 16;
  localparam int PFTA_PAGE_W     = 8;
  localparam int PFTA_WORD_W     = 24;
  localparam int PFTA_LOW_W      = 16;
  localparam int PFTA_HIGH_W     = 8;
  localparam int PFTA_ROW_WORDS  = 64;
  localparam int PFTA_PAGE_WORDS = 512;
  localparam int PFTA_MEM_WORDS  = 4096;
  localparam int PFTA_LOW_LSB    = 0;
  localparam int PFTA_HIGH_LSB   = 16;
  localparam logic [23:0] PFTA_ERASED = 24'hFFFFFF;
  localparam logic [7:0]  PFTA_BYTE_ONES = 8'hFF;

  typedef enum logic [1:0] {
    PFTA_OP_ROW,
    PFTA_OP_WORD,
    PFTA_OP_ERASE,
    PFTA_OP_NONE
  } pfta_nvop_t;
endpackage

// ===== hw/pfta_table_access.sv
// Program flash table-access path: address forming, latches, program/erase
// ============================================================
// Behaviour
// - Program either a full 64-word row or one single word.
// - Erase works only on whole 512-word pages.
// - Target address is page register low byte joined to 16-bit address.
// - Low-part access moves only word bits 15 to 0.
// - High-part access moves only word bits 23 to 16.
// - Low and high accesses each allow word or single-byte transfer.
// - Table access works in normal mode, no special state needed.
// - Flash stays readable, writable, erasable during normal operation.
// - Serial programming uses clock and data pins plus master clear; only master clear acts here.
`timescale 1ns/1ps
module pfta_table_access import pfta_pkg::*; #(
  parameter int MEM_WORDS = PFTA_MEM_WORDS,
  parameter int ROW_WORDS = PFTA_ROW_WORDS,
  parameter int PAGE_WORDS = PFTA_PAGE_WORDS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  table_page_reg_i,
  input  wire logic [15:0] ea_i,
  input  wire logic        table_read_low_op_i,
  input  wire logic        table_read_high_op_i,
  input  wire logic        table_write_low_op_i,
  input  wire logic        table_write_high_op_i,
  input  wire logic        byte_mode_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        nv_start_i,
  input  wire logic [1:0]  nv_op_i,
  input  wire logic        prog_clock_pin_i,
  input  wire logic        prog_data_pin_i,
  input  wire logic        master_clear_pin_i,
  output logic [15:0]      rdata_o,
  output logic             rvalid_o,
  output logic             busy_o,
  output logic             prog_data_pin_o,
  output logic             prog_data_oe_o
);
  localparam int IW = $clog2(MEM_WORDS);
  localparam int RW = $clog2(ROW_WORDS);
  localparam int PW = $clog2(PAGE_WORDS);

  // ============================================================
  // Elaboration checks
  // ============================================================
  // Base masking and the counters assume power-of-two geometry
  if (MEM_WORDS % PAGE_WORDS != 0 || PAGE_WORDS % ROW_WORDS != 0 ||
      ROW_WORDS < 2) begin : g_bad_geometry
    $error("pfta_table_access: unsupported geometry");
  end
  if ((MEM_WORDS & (MEM_WORDS - 1)) != 0 ||
      (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 ||
      (ROW_WORDS & (ROW_WORDS - 1)) != 0) begin : g_bad_power
    $error("pfta_table_access: sizes must be powers of two");
  end
  // The word index must fit below the top of the program address
  if (IW >= PFTA_ADDR_W) begin : g_bad_span
    $error("pfta_table_access: memory exceeds program space");
  end

  // ============================================================
  // Lane helpers
  // ============================================================
  // Byte lane of a low part; shared by the read and the latch merge
  function automatic logic [7:0] pfta_lane(
    input logic [15:0] part,
    input logic        odd
  );
    if (odd)
      return part[PFTA_LOW_LSB + PFTA_HIGH_W +: PFTA_HIGH_W];
    return part[PFTA_LOW_LSB +: PFTA_HIGH_W];
  endfunction

  // Byte results are zero-extended so the core never sees stale upper bits
  function automatic logic [15:0] pfta_zext(
    input logic [7:0] lane
  );
    return {{(PFTA_LOW_W - PFTA_HIGH_W){1'b0}}, lane};
  endfunction

  // ============================================================
  // Address forming
  // ============================================================
  // Word index is the address over two; odd byte picks the upper byte.
  wire [23:0] tgt_addr = {table_page_reg_i, ea_i};
  wire [IW-1:0] word_idx = tgt_addr[IW:1];
  wire          odd_byte = tgt_addr[0];
  wire [RW-1:0] row_slot = word_idx[RW-1:0];

  logic [23:0] flash_mem  [MEM_WORDS];
  logic [23:0] latch_mem  [ROW_WORDS];

  wire [23:0] rd_word = flash_mem[word_idx];
  wire [23:0] lt_word = latch_mem[row_slot];

  // ============================================================
  // Read data selection
  // ============================================================
  // Phantom byte above bit 23 reads as zero on a high-part odd-byte read.
  wire [15:0] low_part  = rd_word[PFTA_LOW_LSB +: PFTA_LOW_W];
  wire [7:0]  high_part = rd_word[PFTA_HIGH_LSB +: PFTA_HIGH_W];
  wire [7:0]  low_lane  = pfta_lane(low_part, odd_byte);
  wire [15:0] low_byte  = pfta_zext(low_lane);
  wire        phantom   = byte_mode_i && odd_byte;
  wire [15:0] rd_low    = byte_mode_i ? low_byte : low_part;
  wire [15:0] rd_high   = phantom ? '0 : pfta_zext(high_part);
  wire        rd_req    = table_read_low_op_i | table_read_high_op_i;

  // ============================================================
  // Latch write merge
  // ============================================================
  // A byte write keeps the other lane of the latch word untouched
  wire [7:0]  wr_byte   = wdata_i[PFTA_LOW_LSB +: PFTA_HIGH_W];
  wire [15:0] lt_low    = lt_word[PFTA_LOW_LSB +: PFTA_LOW_W];
  wire [7:0]  lt_high   = lt_word[PFTA_HIGH_LSB +: PFTA_HIGH_W];
  wire [7:0]  lt_even   = pfta_lane(lt_low, 1'b0);
  wire [7:0]  lt_odd    = pfta_lane(lt_low, 1'b1);
  wire [15:0] lt_lane_w = odd_byte ? {wr_byte, lt_even} : {lt_odd, wr_byte};
  wire [15:0] lt_low_n  = byte_mode_i ? lt_lane_w : wdata_i;
  wire [23:0] lt_low_w  = {lt_high, lt_low_n};
  wire [23:0] lt_high_w = phantom ? lt_word : {wr_byte, lt_low};
  wire        wr_any = table_write_low_op_i | table_write_high_op_i;
  wire [23:0] lt_next = table_write_low_op_i ? lt_low_w : lt_high_w;

  // ============================================================
  // Program and erase sequencing
  // ============================================================
  typedef enum logic [1:0] {
    PFTA_ST_IDLE,
    PFTA_ST_ROW,
    PFTA_ST_ERASE
  } pfta_state_t;

  pfta_state_t  state_ff, nxt_state;
  logic [PW-1:0] cnt_ff, nxt_cnt;
  logic [IW-1:0] base_ff;
  logic [15:0]  rdata_ff;
  logic         rvalid_ff;
  logic         busy_ff;

  // Starts are refused while busy or while master clear holds the core
  wire idle        = state_ff == PFTA_ST_IDLE;
  wire nv_ok       = nv_start_i && idle && master_clear_pin_i;
  wire start_row   = nv_ok && nv_op_i == PFTA_OP_ROW;
  wire start_word  = nv_ok && nv_op_i == PFTA_OP_WORD;
  wire start_erase = nv_ok && nv_op_i == PFTA_OP_ERASE;
  wire last_row  = cnt_ff == PW'(ROW_WORDS - 1);
  wire last_page = cnt_ff == PW'(PAGE_WORDS - 1);
  wire [IW-1:0] row_base  = {word_idx[IW-1:RW], {RW{1'b0}}};
  wire [IW-1:0] page_base = {word_idx[IW-1:PW], {PW{1'b0}}};
  wire [IW-1:0] seq_idx   = base_ff | IW'(cnt_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      PFTA_ST_IDLE: begin
        nxt_cnt = '0;
        if (start_row)
          nxt_state = PFTA_ST_ROW;
        else if (start_erase)
          nxt_state = PFTA_ST_ERASE;
      end
      PFTA_ST_ROW: begin
        nxt_cnt = cnt_ff + PW'(1);
        if (last_row) nxt_state = PFTA_ST_IDLE;
      end
      PFTA_ST_ERASE: begin
        nxt_cnt = cnt_ff + PW'(1);
        if (last_page) nxt_state = PFTA_ST_IDLE;
      end
      default: nxt_state = PFTA_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= PFTA_ST_IDLE;
      cnt_ff    <= '0;
      base_ff   <= '0;
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
      busy_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      // Same source as the state flop, so busy lines up with the sequence
      busy_ff   <= nxt_state != PFTA_ST_IDLE;
      rvalid_ff <= rd_req && idle;
      if (rd_req && idle)
        rdata_ff <= table_read_low_op_i ? rd_low : rd_high;
      if (nv_ok)
        base_ff <= start_erase ? page_base : row_base;
    end
  end

  // Arrays carry no reset: flash contents survive reset like real cells
  always_ff @(posedge mclk_i) begin
    if (wr_any && idle)
      latch_mem[row_slot] <= lt_next;
    if (state_ff == PFTA_ST_ROW)
      flash_mem[seq_idx] <= latch_mem[cnt_ff[RW-1:0]];
    else if (state_ff == PFTA_ST_ERASE)
      flash_mem[seq_idx] <= PFTA_ERASED;
    else if (start_word)
      flash_mem[word_idx] <= lt_word;
  end

  // ============================================================
  // Serial programming pins
  // ============================================================
  // Only master clear is honoured here; the serial protocol is outside.
  logic pdat_ff;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) pdat_ff <= 1'b0;
    else       pdat_ff <= prog_clock_pin_i & prog_data_pin_i & 1'b0;
  end

  assign rdata_o         = rdata_ff;
  assign rvalid_o        = rvalid_ff;
  assign busy_o          = busy_ff;
  assign prog_data_pin_o = pdat_ff;
  assign prog_data_oe_o  = pdat_ff;
endmodule

// ===== testbench/pfta_core_model.sv
// Core model: issues table and nv requests as one-cycle pulses
`timescale 1ns/1ps
module pfta_core_model (
  input wire logic clk_i
);
  logic [7:0]  pg = 8'h00;
  logic [15:0] ea = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [4:0]  req = 5'h00;
  logic        bm = 1'b0;
  logic [1:0]  op = 2'h3;
  logic        mc = 1'b1;
  // Request bits {start,wr_high,wr_low,rd_high,rd_low}, held one cycle
  // Caller orders low write then high write per address
  task automatic go(input logic [4:0] s, input logic [15:0] a, d,
                    input logic b, input logic [1:0] o, input logic m);
    @(negedge clk_i);
    {req, ea, wd, bm, op, mc} = {s, a, d, b, o, m};
    @(negedge clk_i);
    req = 5'h00;
    wd = ~wd; // Released bus shows no stale data
  endtask
endmodule

// ===== testbench/pfta_table_access_props.sv
// Checker: port assertions for the table-access block
`timescale 1ns/1ps
module pfta_tap_props (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        table_read_low_op_i,
  input wire logic        table_read_high_op_i,
  input wire logic        byte_mode_i,
  input wire logic        nv_start_i,
  input wire logic [1:0]  nv_op_i,
  input wire logic        master_clear_pin_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic        busy_o,
  input wire logic        prog_data_pin_o,
  input wire logic        prog_data_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire rd = (table_read_low_op_i | table_read_high_op_i) & !busy_o;
  wire st = nv_start_i & !busy_o & master_clear_pin_i;
  rd_answer_a: assert property (rvalid_o == $past(rd))
    else $error("read answer wrong");
  row_busy_a: assert property (st && nv_op_i == 2'h0 |=>
    busy_o ##63 busy_o ##1 !busy_o) else $error("row busy length");
  page_busy_a: assert property (st && nv_op_i == 2'h2 |=>
    busy_o ##[511:511] busy_o ##1 !busy_o) else $error("erase length");
  word_prog_a: assert property (st && nv_op_i == 2'h1 |=> !busy_o)
    else $error("word program busy");
  clear_refuse_a: assert property (nv_start_i && !master_clear_pin_i
    && !busy_o |=> !busy_o) else $error("start not refused");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(st))
    else $error("busy without start");
  high_part_a: assert property (rvalid_o && $past(table_read_high_op_i)
    |-> rdata_o[15:8] == 8'h00) else $error("high read upper bits");
  byte_zext_a: assert property (rvalid_o && $past(byte_mode_i)
    |-> rdata_o[15:8] == 8'h00) else $error("byte read upper bits");
  pins_idle_a: assert property (!prog_data_oe_o && !prog_data_pin_o)
    else $error("serial data pin driven");
endmodule
bind pfta_table_access pfta_tap_props u_pfta_tap_props (.*);

// ===== testbench/tb_pfta_table_access.sv
// Testbench: table access, latches, program and erase
`timescale 1ns/1ps
module tb_pfta_table_access;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] rdata;
  logic        rvalid;
  logic        busy;
  logic        pins = 1'b0;
  logic        pdo;
  logic        poe;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  pfta_core_model u_pfta_core_model (.clk_i(mclk_i));
  pfta_table_access u_pfta_table_access (.mclk_i(mclk_i), .rst_i(rst_i),
    .table_page_reg_i(u_pfta_core_model.pg), .ea_i(u_pfta_core_model.ea),
    .table_read_low_op_i(u_pfta_core_model.req[0]),
    .table_read_high_op_i(u_pfta_core_model.req[1]),
    .table_write_low_op_i(u_pfta_core_model.req[2]),
    .table_write_high_op_i(u_pfta_core_model.req[3]),
    .nv_start_i(u_pfta_core_model.req[4]), .nv_op_i(u_pfta_core_model.op),
    .byte_mode_i(u_pfta_core_model.bm), .wdata_i(u_pfta_core_model.wd),
    .master_clear_pin_i(u_pfta_core_model.mc), .prog_clock_pin_i(pins),
    .prog_data_pin_i(pins), .rdata_o(rdata), .rvalid_o(rvalid),
    .busy_o(busy), .prog_data_pin_o(pdo), .prog_data_oe_o(poe));
  initial forever #20 mclk_i = ~mclk_i;
  // ==========================================
  // Tasks
  task automatic c(input logic [4:0] s, input logic [15:0] a, d = 16'h0,
                   input logic b = 1'b0, input logic [1:0] o = 2'h3,
                   input logic m = 1'b1);
    u_pfta_core_model.go(s, a, d, b, o, m);
  endtask
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic h, b,
                    input logic [15:0] e);
    c(h ? 5'h02 : 5'h01, a, 16'h0, b);
    chk(rdata, e);
    chk({15'h0, rvalid}, 16'h0001);
  endtask
  // Bounded wait: erase is the longest operation
  task automatic wt;
    for (int i = 0; i < 600 && busy === 1'b1; i++) @(negedge mclk_i);
  endtask
  task automatic t_erase;
    c(5'h10, 16'h0, 16'h0, 1'b0, 2'h2);
    wt();
    rd(16'h0000, 1'b0, 1'b0, 16'hFFFF);
    rd(16'h03FE, 1'b1, 1'b0, 16'h00FF);
  endtask
  task automatic t_word;
    c(5'h04, 16'h0002, 16'h1234);
    c(5'h08, 16'h0002, 16'h0056);
    c(5'h10, 16'h0002, 16'h0, 1'b0, 2'h1);
    chk({15'h0, busy}, 16'h0000);
    rd(16'h0002, 1'b0, 1'b0, 16'h1234);
    rd(16'h0002, 1'b1, 1'b0, 16'h0056);
    rd(16'h0003, 1'b0, 1'b1, 16'h0012);
    rd(16'h0002, 1'b1, 1'b1, 16'h0056);
  endtask
  task automatic t_row;
    for (int i = 0; i < 64; i++) begin
      c(5'h04, 16'(2 * i), 16'hA000 + 16'(i));
      c(5'h08, 16'(2 * i), 16'(i));
    end
    rd(16'h0000, 1'b0, 1'b0, 16'hFFFF);
    c(5'h10, 16'h0, 16'h0, 1'b0, 2'h0);
    c(5'h01, 16'h0);
    chk({15'h0, rvalid}, 16'h0000);
    chk({15'h0, busy}, 16'h0001);
    wt();
    rd(16'h0000, 1'b0, 1'b0, 16'hA000);
    rd(16'h007E, 1'b1, 1'b0, 16'h003F);
  endtask
  task automatic t_master_clear_pin;
    c(5'h10, 16'h0, 16'h0, 1'b0, 2'h2, 1'b0);
    chk({15'h0, busy}, 16'h0000);
    // Serial pins are driven high while the block must keep its data pin released
    pins = 1'b1;
    @(negedge mclk_i);
    chk({14'h0, pdo, poe}, 16'h0000);
  endtask
  task automatic end_sim;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    t_erase();
    t_word();
    t_row();
    t_master_clear_pin();
    end_sim();
  end
endmodule
